// file: src/rci_cause_decode.sv
// priority decoder: one restart cause per cycle from the event inputs
`timescale 1ns/1ps
`default_nettype none
module rci_cause_decode
    import rci_pkg::*;
(
    input  wire logic       por_evt,
    input  wire logic       bor_evt,
    input  wire logic       xpin_evt,
    input  wire logic       wdt_evt,
    input  wire logic       reset_instr,
    input  wire logic       mismatch_evt,
    input  wire logic       stk_over,
    input  wire logic       stk_under,
    input  wire logic       wake_int,
    input  wire logic       stk_rst_en,
    input  wire logic [1:0] pmode,
    rci_evt_if.dec          evt
);
    // ------------------------------------------------------------
    // priority decode
    // ------------------------------------------------------------
    always_comb
    begin
        evt.valid = 1'b1;
        evt.cause = RCI_NONE;
        if (por_evt)
            evt.cause = RCI_POR;
        else if (bor_evt)
            evt.cause = RCI_BOR;
        else if (xpin_evt)
        begin
            case (pmode)
                2'h0:    evt.cause = RCI_PIN_FULL;
                2'h1:    evt.cause = RCI_PIN_RUN;
                default: evt.cause = RCI_PIN_IDLE;
            endcase
        end
        else if (mismatch_evt)
            evt.cause = RCI_MISMATCH;
        else if (wdt_evt)
            evt.cause = (pmode >= 2'h2) ? RCI_WAKE_WDT : RCI_WDT_RUN;
        else if (reset_instr)
            evt.cause = RCI_RESET_INSTR;
        else if (stk_over && stk_rst_en)
            evt.cause = RCI_STK_FULL;
        else if (stk_under)
            evt.cause = stk_rst_en ? RCI_STK_UNF : RCI_STK_UNF_ERR;
        else if (wake_int && pmode >= 2'h1)
            evt.cause = RCI_WAKE_INT;
        else
            evt.valid = 1'b0;
    end
endmodule : rci_cause_decode
`default_nettype wire

// file: src/rci_evt_if.sv
// interface carrying the decoded restart cause from the decoder to the register logic
`timescale 1ns/1ps
`default_nettype none
interface rci_evt_if;
    import rci_pkg::*;
    rci_cause_t cause;
    logic       valid;
    modport dec (output cause, output valid);
    modport use_side (input cause, input valid);
endinterface : rci_evt_if
`default_nettype wire

// file: src/rci_pkg.sv
// package: offsets, field positions, reset values and event codes for the reset-cause block
package rci_pkg;
    // register indexes on the plain register port
    localparam logic [3:0] ADDR_CAUSE    = 4'h0;
    localparam logic [3:0] ADDR_STACK    = 4'h1;
    localparam logic [3:0] ADDR_TOP_U    = 4'h2;
    localparam logic [3:0] ADDR_TOP_H    = 4'h3;
    localparam logic [3:0] ADDR_TOP_L    = 4'h4;
    localparam logic [3:0] ADDR_LAT_U    = 4'h5;
    localparam logic [3:0] ADDR_LAT_H    = 4'h6;
    localparam logic [3:0] ADDR_PC_LO    = 4'h7;
    localparam logic [3:0] ADDR_TBLU     = 4'h8;
    localparam logic [3:0] ADDR_TBLH     = 4'h9;
    localparam logic [3:0] ADDR_TBLL     = 4'ha;
    localparam logic [3:0] ADDR_TBL_DAT  = 4'hb;
    localparam logic [3:0] ADDR_INTC1    = 4'hc;
    localparam logic [3:0] ADDR_INTC2    = 4'hd;
    localparam logic [3:0] ADDR_INTC3    = 4'he;
    localparam logic [3:0] ADDR_EVT      = 4'hf;

    // reset-cause register bit positions (bit 6 unimplemented)
    localparam int CAUSE_IPEN = 7;
    localparam int CAUSE_CFG   = 5;
    localparam int CAUSE_INSTR = 4;
    localparam int CAUSE_TO    = 3;
    localparam int CAUSE_DOWN  = 2;
    localparam int CAUSE_POR  = 1;
    localparam int CAUSE_BOR  = 0;
    localparam logic [7:0] CAUSE_MASK = 8'hbf;

    // stack pointer register: full, underflow, bit 5 unimplemented, level
    localparam int STK_FUL = 7;
    localparam int STK_UNF = 6;
    localparam logic [7:0] STK_MASK  = 8'hdf;
    localparam logic [7:0] STK_LEVEL = 8'h1f;

    localparam logic [4:0] TOP_U_MASK = 5'h1f;
    localparam logic [5:0] TBLU_MASK = 6'h3f;

    localparam logic [7:0] INTC1_RST = 8'h00;
    localparam logic [7:0] INTC2_RST = 8'hff;
    localparam logic [7:0] INTC3_RST = 8'hc0;
    localparam int INTC1_EN_HI = 7;
    localparam int INTC1_EN_LO = 6;

    localparam logic [20:0] PC_RESET   = 21'h000000;
    localparam logic [20:0] VEC_HIGH   = 21'h000008;
    localparam logic [20:0] VEC_LOW    = 21'h000018;
    localparam logic [20:0] PC_STEP    = 21'h000002;

    // event/interrupt status bit positions
    localparam int EVT_HARD  = 0;
    localparam int EVT_WAKE  = 1;
    localparam int EVT_STACK = 2;
    localparam int EVT_W     = 3;

    typedef enum {
        RCI_NONE, RCI_POR, RCI_BOR, RCI_PIN_FULL, RCI_PIN_RUN, RCI_PIN_IDLE,
        RCI_WDT_RUN, RCI_RESET_INSTR, RCI_STK_FULL, RCI_STK_UNF, RCI_STK_UNF_ERR,
        RCI_MISMATCH, RCI_WAKE_WDT, RCI_WAKE_INT
    } rci_cause_t;

    typedef enum {
        RCI_MODE_FULL, RCI_MODE_RUN, RCI_MODE_IDLE
    } rci_pmode_t;
endpackage : rci_pkg

// file: src/rci_reset_init.sv
// reset-cause flags, restart address and forced register values
`timescale 1ns/1ps
`default_nettype none
module rci_reset_init
    import rci_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        por_pin,
    input  wire logic        bor_pin,
    input  wire logic        external_reset_pin_n,
    input  wire logic        watchdog_timeout,
    input  wire logic        reset_instr,
    input  wire logic        mismatch_evt,
    input  wire logic        stk_over,
    input  wire logic        stk_under,
    input  wire logic        wake_int,
    input  wire logic        wake_int_high,
    input  wire logic        stack_error_reset_enable,
    input  wire logic [1:0]  pmode,
    input  wire logic [20:0] pc_current,
    input  wire logic [3:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    output logic      [20:0] restart_pc,
    output logic             restart_load,
    output logic             core_hold,
    output logic             irq
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // pins are asynchronous; first stage feeds only the second
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync_prev;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sync1     <= 3'h0;
            sync2     <= 3'h0;
            sync_prev <= 3'h0;
        end
        else
        begin
            sync1     <= {~external_reset_pin_n, bor_pin, por_pin};
            sync2     <= sync1;
            sync_prev <= sync2;
        end
    end
    // an asserted level causes one restart, at its leading edge
    logic por_evt;
    logic bor_evt;
    logic xpin_evt;
    assign por_evt  = sync2[0] & ~sync_prev[0];
    assign bor_evt  = sync2[1] & ~sync_prev[1];
    assign xpin_evt = sync2[2] & ~sync_prev[2];

    rci_evt_if evt ();
    rci_cause_decode u_dec (
        .por_evt      (por_evt),
        .bor_evt      (bor_evt),
        .xpin_evt     (xpin_evt),
        .wdt_evt      (watchdog_timeout),
        .reset_instr  (reset_instr),
        .mismatch_evt (mismatch_evt),
        .stk_over     (stk_over),
        .stk_under    (stk_under),
        .wake_int     (wake_int),
        .stk_rst_en   (stack_error_reset_enable),
        .pmode        (pmode),
        .evt          (evt)
    );

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]  cause;
    logic [7:0]  stack;
    logic [4:0]  top_u;
    logic [7:0]  top_h;
    logic [7:0]  top_l;
    logic [4:0]  lat_u;
    logic [7:0]  lat_h;
    logic [7:0]  pc_lo;
    logic [5:0]  tblu;
    logic [7:0]  tblh;
    logic [7:0]  tbll;
    logic [7:0]  tbl_dat;
    logic [7:0]  intc1;
    logic [7:0]  intc2;
    logic [7:0]  intc3;
    logic [EVT_W-1:0] evt_stat;
    logic [EVT_W-1:0] evt_mask;
    logic [20:0] restart_pc_q;
    logic        restart_load_q;

    logic [7:0]  next_cause;
    logic [7:0]  next_stack;
    logic [4:0]  next_top_u;
    logic [7:0]  next_top_h;
    logic [7:0]  next_top_l;
    logic [4:0]  next_lat_u;
    logic [7:0]  next_lat_h;
    logic [7:0]  next_pc_lo;
    logic [5:0]  next_tblu;
    logic [7:0]  next_tblh;
    logic [7:0]  next_tbll;
    logic [7:0]  next_tbl_dat;
    logic [7:0]  next_intc1;
    logic [7:0]  next_intc2;
    logic [7:0]  next_intc3;
    logic [EVT_W-1:0] next_evt_stat;
    logic [EVT_W-1:0] next_evt_mask;
    logic [20:0] next_restart_pc;
    logic        next_restart_load;
    logic [7:0]  next_rdata;

    logic hard;
    logic power;
    logic wake;
    logic [20:0] wake_pc;
    logic [20:0] pc_next_seq;
    logic [EVT_W-1:0] evt_set;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_cause  = cause;
        next_stack  = stack;
        next_top_u  = top_u;
        next_top_h  = top_h;
        next_top_l  = top_l;
        next_lat_u  = lat_u;
        next_lat_h  = lat_h;
        next_pc_lo  = pc_lo;
        next_tblu   = tblu;
        next_tblh   = tblh;
        next_tbll   = tbll;
        next_tbl_dat = tbl_dat;
        next_intc1  = intc1;
        next_intc2  = intc2;
        next_intc3  = intc3;
        next_evt_mask     = evt_mask;
        next_restart_pc   = restart_pc_q;
        next_restart_load = 1'b0;
        pc_next_seq = pc_current + PC_STEP;
        wake_pc     = pc_next_seq;

        // software writes first, so any hardware update below wins
        if (wr)
        begin
            case (addr)
                ADDR_CAUSE:  next_cause  = wdata & CAUSE_MASK;
                ADDR_STACK:  next_stack  = wdata & STK_MASK;
                ADDR_TOP_U:  next_top_u  = wdata[4:0];
                ADDR_TOP_H:  next_top_h  = wdata;
                ADDR_TOP_L:  next_top_l  = wdata;
                ADDR_LAT_U:  next_lat_u  = wdata[4:0];
                ADDR_LAT_H:  next_lat_h  = wdata;
                ADDR_PC_LO:  next_pc_lo  = wdata;
                ADDR_TBLU:   next_tblu   = wdata[5:0];
                ADDR_TBLH:   next_tblh   = wdata;
                ADDR_TBLL:   next_tbll   = wdata;
                ADDR_TBL_DAT: next_tbl_dat = wdata;
                ADDR_INTC1:  next_intc1  = wdata;
                ADDR_INTC2:  next_intc2  = wdata;
                ADDR_INTC3:  next_intc3  = wdata;
                default:     next_evt_mask = wdata[EVT_W-1:0];
            endcase
        end

        power = (evt.cause == RCI_POR) || (evt.cause == RCI_BOR);
        wake  = (evt.cause == RCI_WAKE_WDT) || (evt.cause == RCI_WAKE_INT);
        hard  = evt.valid && !wake && (evt.cause != RCI_STK_UNF_ERR);

        // flag updates; untouched flags stay as they were
        case (evt.cause)
            RCI_POR:
            begin
                next_cause[CAUSE_CFG]   = 1'b1;
                next_cause[CAUSE_INSTR] = 1'b1;
                next_cause[CAUSE_TO]    = 1'b1;
                next_cause[CAUSE_DOWN]  = 1'b1;
                next_cause[CAUSE_POR]   = 1'b0;
                next_cause[CAUSE_BOR]   = 1'b0;
                next_stack[STK_FUL]     = 1'b0;
                next_stack[STK_UNF]     = 1'b0;
            end
            RCI_BOR:
            begin
                next_cause[CAUSE_CFG]   = 1'b1;
                next_cause[CAUSE_INSTR] = 1'b1;
                next_cause[CAUSE_TO]    = 1'b1;
                next_cause[CAUSE_DOWN]  = 1'b1;
                next_cause[CAUSE_BOR]   = 1'b0;
            end
            RCI_RESET_INSTR: next_cause[CAUSE_INSTR] = 1'b0;
            RCI_WDT_RUN:     next_cause[CAUSE_TO] = 1'b0;
            RCI_PIN_FULL:    next_cause = next_cause;
            RCI_PIN_RUN:     next_cause[CAUSE_TO] = 1'b1;
            RCI_PIN_IDLE:
            begin
                next_cause[CAUSE_TO]   = 1'b1;
                next_cause[CAUSE_DOWN] = 1'b0;
            end
            RCI_MISMATCH:    next_cause[CAUSE_CFG] = 1'b0;
            RCI_STK_FULL:    next_stack[STK_FUL]  = 1'b1;
            RCI_STK_UNF:     next_stack[STK_UNF]  = 1'b1;
            RCI_STK_UNF_ERR: next_stack[STK_UNF]  = 1'b1;
            RCI_WAKE_WDT:
            begin
                next_cause[CAUSE_TO]   = 1'b0;
                next_cause[CAUSE_DOWN] = 1'b0;
            end
            RCI_WAKE_INT:    next_cause[CAUSE_DOWN] = 1'b0;
            default:         next_cause = next_cause;
        endcase

        if (hard)
        begin
            next_top_u  = 5'h00;
            next_top_h  = 8'h00;
            next_top_l  = 8'h00;
            next_lat_u  = 5'h00;
            next_lat_h  = 8'h00;
            next_pc_lo  = 8'h00;
            next_tblu   = 6'h00;
            next_tblh   = 8'h00;
            next_tbll   = 8'h00;
            next_tbl_dat = 8'h00;
            // brown-out and stack-error resets keep stack flags, other hard resets clear all
            if (power)
                next_stack = next_stack & ~STK_LEVEL;
            else if (evt.cause == RCI_STK_FULL || evt.cause == RCI_STK_UNF)
                next_stack = next_stack & (STK_MASK & ~STK_LEVEL);
            else
                next_stack = 8'h00;
            next_intc1 = {INTC1_RST[7:1],
                          (evt.cause == RCI_POR) ? INTC1_RST[0] : intc1[0]};
            next_intc2 = INTC2_RST;
            next_intc3 = INTC3_RST;
            next_restart_pc   = PC_RESET;
            next_restart_load = 1'b1;
        end
        else if (wake)
        begin
            if (evt.cause == RCI_WAKE_INT
                && (intc1[INTC1_EN_HI] || intc1[INTC1_EN_LO]))
            begin
                wake_pc    = wake_int_high ? VEC_HIGH : VEC_LOW;
                // return address pushed to the top of stack
                next_top_u = pc_current[20:16];
                next_top_h = pc_current[15:8];
                next_top_l = pc_current[7:0];
                next_stack = {stack[7:5], stack[4:0] + 5'h01};
            end
            next_pc_lo        = wake_pc[7:0];
            next_restart_pc   = wake_pc;
            next_restart_load = 1'b1;
        end

        // status: hardware set wins over a write-one clear
        evt_set = {evt.cause == RCI_STK_FULL || evt.cause == RCI_STK_UNF
                   || evt.cause == RCI_STK_UNF_ERR, wake, hard};
        next_evt_stat = evt_stat;
        if (wr && addr == ADDR_EVT)
            next_evt_stat = evt_stat & ~wdata[EVT_W-1:0];
        next_evt_stat = next_evt_stat | evt_set;

        case (addr)
            ADDR_CAUSE:  next_rdata = cause;
            ADDR_STACK:  next_rdata = stack;
            ADDR_TOP_U:  next_rdata = {3'h0, top_u};
            ADDR_TOP_H:  next_rdata = top_h;
            ADDR_TOP_L:  next_rdata = top_l;
            ADDR_LAT_U:  next_rdata = {3'h0, lat_u};
            ADDR_LAT_H:  next_rdata = lat_h;
            ADDR_PC_LO:  next_rdata = pc_lo;
            ADDR_TBLU:   next_rdata = {2'h0, tblu};
            ADDR_TBLH:   next_rdata = tblh;
            ADDR_TBLL:   next_rdata = tbll;
            ADDR_TBL_DAT: next_rdata = tbl_dat;
            ADDR_INTC1:  next_rdata = intc1;
            ADDR_INTC2:  next_rdata = intc2;
            ADDR_INTC3:  next_rdata = intc3;
            default:     next_rdata = {1'b0, evt_mask, 1'b0, evt_stat};
        endcase
        if (!rd)
            next_rdata = 8'h00;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // rst stands for the power-on state of the flops themselves
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cause  <= 8'h1c;
            stack  <= 8'h00;
            top_u  <= 5'h00;
            top_h  <= 8'h00;
            top_l  <= 8'h00;
            lat_u  <= 5'h00;
            lat_h  <= 8'h00;
            pc_lo  <= 8'h00;
            tblu   <= 6'h00;
            tblh   <= 8'h00;
            tbll   <= 8'h00;
            tbl_dat <= 8'h00;
            intc1  <= INTC1_RST;
            intc2  <= INTC2_RST;
            intc3  <= INTC3_RST;
            evt_stat       <= 3'h0;
            evt_mask       <= 3'h0;
            restart_pc_q   <= PC_RESET;
            restart_load_q <= 1'b0;
            rdata          <= 8'h00;
        end
        else
        begin
            cause  <= next_cause;
            stack  <= next_stack;
            top_u  <= next_top_u;
            top_h  <= next_top_h;
            top_l  <= next_top_l;
            lat_u  <= next_lat_u;
            lat_h  <= next_lat_h;
            pc_lo  <= next_pc_lo;
            tblu   <= next_tblu;
            tblh   <= next_tblh;
            tbll   <= next_tbll;
            tbl_dat <= next_tbl_dat;
            intc1  <= next_intc1;
            intc2  <= next_intc2;
            intc3  <= next_intc3;
            evt_stat       <= next_evt_stat;
            evt_mask       <= next_evt_mask;
            restart_pc_q   <= next_restart_pc;
            restart_load_q <= next_restart_load;
            rdata          <= next_rdata;
        end
    end

    assign restart_pc   = restart_pc_q;
    assign restart_load = restart_load_q;
    // core held while any reset level stands
    assign core_hold    = sync2[0] | sync2[1] | sync2[2];
    assign irq          = |(evt_stat & evt_mask);
endmodule : rci_reset_init
`default_nettype wire

// file: tb/rci_reset_init_props.sv
// checker: concurrent properties on the ports of the reset-cause block
`timescale 1ns/1ps
`default_nettype none
module rci_reset_init_props
    import rci_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        por_pin,
    input wire logic        bor_pin,
    input wire logic        external_reset_pin_n,
    input wire logic        watchdog_timeout,
    input wire logic        reset_instr,
    input wire logic        mismatch_evt,
    input wire logic        stk_over,
    input wire logic        stk_under,
    input wire logic        wake_int,
    input wire logic        wake_int_high,
    input wire logic        stack_error_reset_enable,
    input wire logic [1:0]  pmode,
    input wire logic [20:0] pc_current,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    input wire logic [20:0] restart_pc,
    input wire logic        restart_load,
    input wire logic        core_hold
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic pulses;
    assign pulses = watchdog_timeout | reset_instr | mismatch_evt | stk_over | stk_under;
    // two sync flops plus the sampling edge: three cycles of a steady pin
    sequence pin_low3;
        !external_reset_pin_n [*3];
    endsequence
    // power detect levels hold the core as well, so all three must be idle
    sequence pin_high3;
        (external_reset_pin_n && !por_pin && !bor_pin) [*3];
    endsequence
    sequence hard_restart;
        restart_load && restart_pc == PC_RESET;
    endsequence
    a_wdt_full: assert property (
        watchdog_timeout && !mismatch_evt && pmode == 2'd0 |=> hard_restart)
        else $error("watchdog at full power did not restart at zero");
    a_wdt_wake: assert property (
        watchdog_timeout && !mismatch_evt && pmode[1]
        |=> restart_load && restart_pc == $past(pc_current) + PC_STEP)
        else $error("watchdog wake did not continue at pc plus two");
    a_instr_restart: assert property (
        reset_instr && !watchdog_timeout && !mismatch_evt |=> hard_restart)
        else $error("reset instruction did not restart at zero");
    a_mismatch_restart: assert property (mismatch_evt |=> hard_restart)
        else $error("mismatch did not restart at zero");
    a_stack_restart: assert property (
        stk_over && stack_error_reset_enable && !(watchdog_timeout | reset_instr | mismatch_evt)
        |=> hard_restart)
        else $error("stack overflow with enable did not restart at zero");
    a_wake_target: assert property (
        wake_int && pmode != 2'd0 && !pulses |=> restart_load &&
        (restart_pc == $past(pc_current) + PC_STEP ||
         restart_pc == ($past(wake_int_high) ? VEC_HIGH : VEC_LOW)))
        else $error("interrupt wake went to a wrong address");
    a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_pin_hold: assert property (pin_low3 |-> core_hold)
        else $error("core not held while pin reset stands");
    a_pin_free: assert property (pin_high3 |-> !core_hold)
        else $error("core held with pin released");
endmodule : rci_reset_init_props
`default_nettype wire

// file: tb/rci_reset_init_tb.sv
// testbench: drives the reset-cause block and checks flags, restart address and registers
`timescale 1ns/1ps
`default_nettype none
module rci_reset_init_tb;
    import rci_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  pp = 2'b00;
    logic        pin_n = 1'b1;
    logic [5:0]  pv = 6'h00;
    logic        wih = 1'b0;
    logic        sere = 1'b0;
    logic [1:0]  pmode = 2'h0;
    logic [20:0] pc_cur = 21'h001234;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  rdata;
    logic [20:0] restart_pc;
    logic        restart_load;
    logic        core_hold;
    logic        irq;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    always #25 mclk = ~mclk;
    rci_reset_init u_dut (.mclk(mclk), .rst(rst), .por_pin(pp[0]), .bor_pin(pp[1]),
        .external_reset_pin_n(pin_n), .watchdog_timeout(pv[0]), .reset_instr(pv[1]),
        .mismatch_evt(pv[2]), .stk_over(pv[3]), .stk_under(pv[4]), .wake_int(pv[5]),
        .wake_int_high(wih), .stack_error_reset_enable(sere), .pmode(pmode),
        .pc_current(pc_cur), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .restart_pc(restart_pc), .restart_load(restart_load), .core_hold(core_hold),
        .irq(irq));
    // ------------------------------------------------------------
    // bus, event and compare tasks
    // ------------------------------------------------------------
    task results;
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    task chk(input logic [20:0] got, input logic [20:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge mclk);
        rd <= 1'b1; addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask : rchk
    task pulse(input logic [5:0] m, input logic ld);
        @(posedge mclk);
        pv <= m;
        @(posedge mclk);
        pv <= 6'h00;
        #1;
        chk(restart_load, ld);
    endtask : pulse
    // pin restarts pass a synchroniser, so the wait is bounded, not exact
    task wait_load;
        #1;
        for (int i = 0; i < 12 && restart_load !== 1'b1; i++)
        begin
            @(posedge mclk);
            #1;
        end
        chk(restart_load, 1'b1);
        chk(restart_pc, PC_RESET);
    endtask : wait_load
    task pin(input logic [1:0] m, input logic [7:0] e);
        @(posedge mclk);
        pmode <= m; pin_n <= 1'b0;
        wait_load();
        chk(core_hold, 1'b1);
        @(posedge mclk);
        pin_n <= 1'b1; pmode <= 2'd0;
        repeat (4) @(posedge mclk);
        rchk(ADDR_CAUSE, 8'hff, e);
    endtask : pin
    task pwr(input logic [1:0] m);
        @(posedge mclk);
        pp <= m;
        wait_load();
        @(posedge mclk);
        pp <= 2'b00;
        repeat (4) @(posedge mclk);
    endtask : pwr
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset_irq;
        rchk(ADDR_CAUSE, 8'hff, 8'h1c);
        rchk(ADDR_STACK, 8'hff, 8'h00);
        rchk(ADDR_INTC2, 8'hff, INTC2_RST);
        rchk(ADDR_INTC3, 8'hff, INTC3_RST);
        wr_reg(ADDR_EVT, 8'h07);
        rchk(ADDR_EVT, 8'hff, 8'h70);
        pulse(6'h02, 1'b1);
        rchk(ADDR_EVT, 8'hff, 8'h71);
        chk(irq, 1'b1);
        wr_reg(ADDR_EVT, 8'h00);
        chk(irq, 1'b0);
        rchk(ADDR_EVT, 8'hff, 8'h01);
        wr_reg(ADDR_EVT, 8'h01);
        rchk(ADDR_EVT, 8'hff, 8'h10);
    endtask : t_reset_irq
    task t_flags;
        wr_reg(ADDR_CAUSE, 8'hbf);
        rchk(ADDR_CAUSE, 8'hff, 8'hbf);
        pulse(6'h03, 1'b1);
        rchk(ADDR_CAUSE, 8'hff, 8'hb7);
        pulse(6'h02, 1'b1);
        rchk(ADDR_CAUSE, 8'hff, 8'ha7);
        pulse(6'h04, 1'b1);
        rchk(ADDR_CAUSE, 8'hff, 8'h87);
        pin(2'd0, 8'h87);
        pin(2'd2, 8'h8b);
        pwr(2'b10);
        rchk(ADDR_CAUSE, 8'hff, 8'hbe);
        pulse(6'h01, 1'b1);
        pin(2'd1, 8'hbe);
    endtask : t_flags
    task t_wake;
        wr_reg(ADDR_TBLL, 8'h5a);
        @(posedge mclk);
        pmode <= 2'd2;
        pulse(6'h20, 1'b1);
        chk(restart_pc, 21'h001236);
        rchk(ADDR_CAUSE, 8'hff, 8'hba);
        rchk(ADDR_TBLL, 8'hff, 8'h5a);
        wr_reg(ADDR_INTC1, 8'h80);
        for (int h = 0; h < 2; h++)
        begin
            @(posedge mclk);
            wih <= h[0];
            pulse(6'h20, 1'b1);
            chk(restart_pc, h[0] ? VEC_HIGH : VEC_LOW);
        end
        rchk(ADDR_INTC1, 8'hff, 8'h80);
        pulse(6'h01, 1'b1);
        chk(restart_pc, 21'h001236);
        rchk(ADDR_CAUSE, 8'hff, 8'hb2);
        @(posedge mclk);
        pmode <= 2'd0;
        pulse(6'h02, 1'b1);
        chk(restart_pc, PC_RESET);
        rchk(ADDR_CAUSE, 8'hff, 8'ha2);
        rchk(ADDR_TBLL, 8'hff, 8'h00);
        rchk(ADDR_TOP_L, 8'hff, 8'h00);
        rchk(ADDR_INTC1, 8'hfe, 8'h00);
    endtask : t_wake
    task t_stack_power;
        @(posedge mclk);
        sere <= 1'b1;
        pulse(6'h08, 1'b1);
        chk(restart_pc, PC_RESET);
        rchk(ADDR_STACK, 8'hff, 8'h80);
        @(posedge mclk);
        sere <= 1'b0;
        pulse(6'h10, 1'b0);
        rchk(ADDR_STACK, 8'h40, 8'h40);
        pwr(2'b10);
        rchk(ADDR_STACK, 8'hff, 8'hc0);
        pwr(2'b11);
        rchk(ADDR_CAUSE, 8'h3f, 8'h3c);
    endtask : t_stack_power
    // ------------------------------------------------------------
    // sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt++;
            results();
        end
    end
    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        t_reset_irq();
        t_flags();
        t_wake();
        t_stack_power();
        results();
    end
endmodule : rci_reset_init_tb
bind rci_reset_init rci_reset_init_props u_props (.mclk(mclk), .rst(rst),
    .por_pin(por_pin), .bor_pin(bor_pin),
    .external_reset_pin_n(external_reset_pin_n), .watchdog_timeout(watchdog_timeout),
    .reset_instr(reset_instr), .mismatch_evt(mismatch_evt), .stk_over(stk_over),
    .stk_under(stk_under), .wake_int(wake_int), .wake_int_high(wake_int_high),
    .stack_error_reset_enable(stack_error_reset_enable), .pmode(pmode),
    .pc_current(pc_current), .rd(rd), .rdata(rdata), .restart_pc(restart_pc),
    .restart_load(restart_load), .core_hold(core_hold));
`default_nettype wire
